// File: sri_pkg.sv
// Shared constants for the asynchronous static RAM controller.
// Assumes a 100 MHz ref_clk; all pin timing is expressed in whole cycles.
package sri_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;
	// Slowest speed grade figures, in ns
	localparam int READ_CYCLE_TIME_NS = 35;
	localparam int WRITE_PULSE_NS = 30;
	localparam int DATA_SETUP_NS = 15;
	localparam int ACCESS_NS = 35;
	localparam int WRITE_RECOVERY_NS = 2;
	localparam int RETENTION_SELECT_SETUP_NS = 0;
	// Least times round up
	localparam int READ_CYCLE_CYC =
		(READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_PULSE_CYC =
		(WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC =
		(ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	typedef enum logic [2:0] {
		SRI_IDLE, SRI_READ, SRI_WRITE, SRI_RECOVER, SRI_RETAIN, SRI_WAKE
	} sri_state_e;
endpackage : sri_pkg

// File: sri_sync.sv
// Two-flop synchroniser for a level arriving from outside ref_clk.
// Assumes the input is a slowly changing level.
`timescale 1ns/100ps
`default_nettype none
module sri_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             srst,
	// Level in and out
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : sri_sync
`default_nettype wire

// File: sri_ctrl.sv
// Controller that drives a 32K x 8 asynchronous static RAM by its pins.
// Assumes the RAM pins are joined directly; one request at a time on the
// user side, data lines resolved by the testbench from data_oe.
`timescale 1ns/100ps
`default_nettype none
module sri_ctrl #(
	parameter int ADDR_W = sri_pkg::ADDR_W,
	parameter int DATA_W = sri_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              srst,
	// User request
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output var  logic              req_ready,
	// User answer
	output var  logic              rsp_valid,
	output var  logic [DATA_W-1:0] rsp_rdata,
	// Power management
	input  wire logic              retain_req,
	input  wire logic              supply_good,
	output var  logic              retained,
	// RAM pins
	output var  logic [ADDR_W-1:0] address_lines,
	output var  logic              chip_sel_n,
	output var  logic              out_gate_n,
	output var  logic              write_strobe_n,
	input  wire logic [DATA_W-1:0] data_lines_in,
	output var  logic [DATA_W-1:0] data_lines_out,
	output var  logic              data_oe
);
	sri_pkg::sri_state_e state;
	sri_pkg::sri_state_e next_state;
	logic [sri_pkg::CNT_W-1:0] cnt;
	logic [DATA_W-1:0]         data_sync;
	logic                      supply_sync;

	localparam logic [sri_pkg::CNT_W-1:0] READ_LAST =
		sri_pkg::CNT_W'(sri_pkg::ACCESS_CYC);
	localparam logic [sri_pkg::CNT_W-1:0] WRITE_LAST =
		sri_pkg::CNT_W'(sri_pkg::WRITE_PULSE_CYC);
	localparam logic [sri_pkg::CNT_W-1:0] RECOVER_LAST =
		sri_pkg::CNT_W'(sri_pkg::RECOVERY_CYC);
	localparam logic [sri_pkg::CNT_W-1:0] WAKE_LAST =
		sri_pkg::CNT_W'(sri_pkg::READ_CYCLE_CYC);

	// Read data is taken two flops late, so the read strobe stays on three
	// more cycles than the access time; slower but metastability-safe.
	sri_sync #(.WIDTH(DATA_W + 1)) u_sync (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.async_in ({supply_good, data_lines_in}),
		.sync_out ({supply_sync, data_sync})
	);

	wire in_idle   = (state == sri_pkg::SRI_IDLE);
	wire take_req  = in_idle && req_valid && !retain_req;
	wire read_done = (state == sri_pkg::SRI_READ) && (cnt == READ_LAST + 4'h2);
	wire cnt_done  = ((state == sri_pkg::SRI_WRITE) && (cnt == WRITE_LAST))
		|| ((state == sri_pkg::SRI_RECOVER) && (cnt == RECOVER_LAST))
		|| ((state == sri_pkg::SRI_WAKE) && (cnt == WAKE_LAST))
		|| read_done;

	always_comb begin
		next_state = state;
		unique case (state)
			sri_pkg::SRI_IDLE: begin
				if (retain_req)
					next_state = sri_pkg::SRI_RETAIN;
				else if (req_valid)
					next_state = req_write ? sri_pkg::SRI_WRITE
						: sri_pkg::SRI_READ;
			end
			sri_pkg::SRI_READ: begin
				if (cnt_done)
					next_state = sri_pkg::SRI_IDLE;
			end
			sri_pkg::SRI_WRITE: begin
				if (cnt_done)
					next_state = sri_pkg::SRI_RECOVER;
			end
			sri_pkg::SRI_RECOVER: begin
				if (cnt_done)
					next_state = sri_pkg::SRI_IDLE;
			end
			sri_pkg::SRI_RETAIN: begin
				if (!retain_req && supply_sync)
					next_state = sri_pkg::SRI_WAKE;
			end
			sri_pkg::SRI_WAKE: begin
				if (!supply_sync)
					next_state = sri_pkg::SRI_RETAIN;
				else if (cnt_done)
					next_state = sri_pkg::SRI_IDLE;
			end
		endcase
	end

	// Pin levels for the coming cycle; each pin is decoded from next_state
	wire next_read  = (next_state == sri_pkg::SRI_READ);
	wire next_write = (next_state == sri_pkg::SRI_WRITE);
	wire next_sel   = next_read || next_write;
	wire next_hold  = (next_state == sri_pkg::SRI_RECOVER);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= sri_pkg::SRI_IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= (next_state != state) ? '0 : cnt + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			chip_sel_n     <= 1'b1;
			out_gate_n     <= 1'b1;
			write_strobe_n <= 1'b1;
			data_oe        <= 1'b0;
		end else begin
			// Select and strobe fall together and rise together, so the
			// write interval is exactly the strobe pulse.
			chip_sel_n     <= !next_sel;
			write_strobe_n <= !next_write;
			// Gate held high while writing keeps the RAM off the bus
			out_gate_n     <= !next_read;
			data_oe        <= next_write || next_hold;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			address_lines  <= '0;
			data_lines_out <= '0;
		end else if (take_req) begin
			address_lines  <= req_addr;
			data_lines_out <= req_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			retained  <= 1'b0;
		end else begin
			req_ready <= (next_state == sri_pkg::SRI_IDLE) && !take_req;
			rsp_valid <= read_done || ((state == sri_pkg::SRI_RECOVER)
				&& cnt_done);
			if (read_done)
				rsp_rdata <= data_sync;
			retained  <= (next_state == sri_pkg::SRI_RETAIN);
		end
	end
endmodule : sri_ctrl
`default_nettype wire

// File: sri_ctrl_assertions.sv
// Pin sequencing checks for the RAM controller.
// Assumes it is bound to sri_ctrl.
`timescale 1ns/100ps
`default_nettype none
module sri_ctrl_assertions (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        chip_sel_n,
	input wire logic        out_gate_n,
	input wire logic        write_strobe_n,
	input wire logic        data_oe,
	input wire logic        retained,
	input wire logic        supply_good,
	input wire logic [14:0] address_lines,
	input wire logic [7:0]  data_lines_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// 30 ns least strobe is three cycles
	sequence strobe_low;
		!write_strobe_n[*3];
	endsequence
	wr_pulse_a: assert property ($fell(write_strobe_n) |-> strobe_low)
		else $error("write strobe too short");
	wr_sel_a: assert property (!write_strobe_n |-> !chip_sel_n && data_oe)
		else $error("strobe low without select or data");
	rd_strobe_a: assert property (!out_gate_n |-> write_strobe_n)
		else $error("strobe low during read");
	wr_gate_a: assert property (!write_strobe_n |-> out_gate_n)
		else $error("gate low during write");
	wr_hold_a: assert property ($rose(write_strobe_n) |-> data_oe &&
		$stable(address_lines) && $stable(data_lines_out))
		else $error("address or data moved at write end");
	ret_sel_a: assert property (retained |-> chip_sel_n)
		else $error("selected while retained");
	wake_sel_a: assert property (retained && $rose(supply_good) |->
		chip_sel_n[*5]) else $error("selected too soon after wake");
endmodule : sri_ctrl_assertions
`default_nettype wire

// File: sri_ram_model.sv
// Behavioural 32K x 8 asynchronous static RAM.
// Assumes the bench resolves the shared data lines.
`timescale 1ns/100ps
`default_nettype none
module sri_ram_model (
	input  wire logic [14:0] address_lines,
	input  wire logic        chip_sel_n,
	input  wire logic        out_gate_n,
	input  wire logic        write_strobe_n,
	input  wire logic [7:0]  data_lines,
	output var  logic [7:0]  ram_q
);
	logic [7:0] mem [32768];
	logic [7:0] hold = 8'h00;
	logic       ram_oe;
	wire        write_n = chip_sel_n | write_strobe_n;
	// Stored as the overlap ends, so late data still lands
	always @(posedge write_n) mem[address_lines] = data_lines;
	assign ram_oe = !chip_sel_n && !out_gate_n && write_strobe_n;
	// Released lines show the inverse, never a stale copy
	assign ram_q = ram_oe ? mem[address_lines] : ~hold;
	always @(ram_q) if (ram_oe) hold = ram_q;
endmodule : sri_ram_model
`default_nettype wire

// File: test_sri_ctrl.sv
// Self-checking bench for sri_ctrl against a RAM model.
// Assumes 100 MHz ref_clk; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module test_sri_ctrl;
	logic        ref_clk = 0, srst = 1, req_valid = 0, req_write = 0;
	logic [14:0] req_addr = 15'h0, address_lines;
	logic [7:0]  req_wdata = 8'h0, rsp_rdata, data_lines_out, ram_q;
	logic        retain_req = 0, supply_good = 1, req_ready, rsp_valid;
	logic        retained, chip_sel_n, out_gate_n, write_strobe_n, data_oe;
	wire  [7:0]  data_lines_in = data_oe ? data_lines_out : ram_q;
	int          mismatches = 0, cmp_count = 0;
	// Write flag, address, data or expected byte
	logic [23:0] rows [8] = '{24'h8000a5, 24'hffff3c, 24'hc0000f, 24'h0000a5,
		24'h7fff3c, 24'hffffc3, 24'h7fffc3, 24'h40000f};
	always #5 ref_clk = ~ref_clk;
	sri_ctrl i_sri_ctrl (.*);
	sri_ram_model i_sri_ram_model (.data_lines(data_lines_in), .*);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("compares=%0d mismatches=%0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		n = 0;
		// Offer only once the controller is idle; it takes at the next edge
		while (req_ready !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge ref_clk);
		req_valid = 0;
		do @(negedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 40);
		if (n >= 40) begin
			mismatches++;
			test_done();
		end
		if (!w) chk(rsp_rdata, d);
	endtask : op
	initial begin
		repeat (12) @(negedge ref_clk);
		srst = 0;
		foreach (rows[i]) op(rows[i][23], rows[i][22:8], rows[i][7:0]);
		// A reset in mid-run must park the select, strobe, gate and data_oe pins
		srst = 1;
		@(negedge ref_clk);
		chk(chip_sel_n & write_strobe_n & out_gate_n, 8'h1);
		chk(data_oe | req_ready, 8'h0);
		srst = 0;
		retain_req = 1;
		repeat (3) @(negedge ref_clk);
		supply_good = 0;
		repeat (3) @(negedge ref_clk);
		chk(retained & chip_sel_n, 8'h1);
		chk(req_ready, 8'h0);
		supply_good = 1;
		retain_req = 0;
		op(1'b0, 15'h4000, 8'h0f);
		test_done();
	end
endmodule : test_sri_ctrl
bind sri_ctrl sri_ctrl_assertions i_sri_ctrl_assertions (.*);
`default_nettype wire
